// ---- cbt_pkg.sv ----
// constants, types and register map of the can bit timing logic
package cbt_pkg;

  // register word offsets on the wishbone slave
  localparam logic [3:0] CBT_CONFIG_OFF = 4'h0;
  localparam logic [3:0] CBT_STATUS_OFF = 4'h4;
  localparam logic [3:0] CBT_COUNT_OFF = 4'h8;

  // field positions of the configuration word
  localparam int CBT_PRESC_LSB = 0;
  localparam int CBT_JUMP_LSB = 6;
  localparam int CBT_PROP_LSB = 8;
  localparam int CBT_PH1_LSB = 11;
  localparam int CBT_PH2_LSB = 14;
  localparam int CBT_TRIPLE_BIT = 17;
  localparam int CBT_LSEL_BIT = 18;
  localparam int CBT_CFG_W = 19;

  // status word field positions
  localparam int CBT_ST_BIT = 0;
  localparam int CBT_ST_RX = 1;
  localparam int CBT_ST_SEG_LSB = 2;

  // reset values
  localparam logic [CBT_CFG_W-1:0] CBT_CONFIG_RST = 19'h00000;
  localparam logic [31:0] CBT_UNMAPPED_DATA = 32'h00000000;

  // fixed segment lengths in quanta
  localparam logic [3:0] CBT_SYNC_LEN = 4'h1;
  localparam logic [3:0] CBT_PROCESSING_TIME = 4'h2;
  localparam logic [3:0] CBT_MIN_PH2 = 4'h1;

  // oscillator clock
  localparam int CBT_CLK_PERIOD_NS = 20;

  typedef struct packed {
    logic phase_two_length_select;
    logic triple_sample_select;
    logic [2:0] phase_two_length_field;
    logic [2:0] phase_one_length_field;
    logic [2:0] propagation_length_field;
    logic [1:0] jump_width;
    logic [5:0] quantum_prescaler;
  } cbt_cfg_s;

  typedef enum logic [3:0] {
    SEG_SYNC = 4'h1,
    SEG_PROP = 4'h2,
    SEG_PH1 = 4'h4,
    SEG_PH2 = 4'h8
  } cbt_seg_e;

endpackage

// ---- cbt_core.sv ----
// can bit timing, synchronisation and sampling with wishbone config
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module cbt_core
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // can line through the transceiver
  input wire logic can_rx_i,
  output logic can_tx_o,
  // protocol engine
  input wire logic bus_idle_i,
  input wire logic transmitting_i,
  input wire logic tx_bit_i,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic bit_start_o
);

  cbt_cfg_s cfg_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] resync_cnt_reg;
  logic [15:0] hard_cnt_reg;

  // line synchroniser; rx_meta_reg feeds only rx_sync_reg
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;

  logic [5:0] presc_cnt_reg;
  logic half_ph_reg;
  logic half_tick;
  logic tq_tick;

  cbt_seg_e seg_reg;
  logic [3:0] cnt_reg;
  logic [3:0] ps1_eff_reg;
  logic [3:0] ps2_eff_reg;
  logic sync_done_reg;
  logic [1:0] hist_reg;
  logic sample_reg;

  logic [3:0] prop_len;
  logic [3:0] ps1_len;
  logic [3:0] ps2_len;
  logic [2:0] jump_len;
  logic [4:0] jump_w;
  logic fall_edge;
  logic edge_used;
  logic hard_sync;
  logic pos_region;
  logic neg_region;
  logic [4:0] err_pos;
  logic [4:0] err_neg;
  logic restart;
  logic lengthen;
  logic shorten;
  logic sample_now;
  logic bit_end;
  logic voted;
  logic [3:0] ps2_short;

  // ---------------- configuration decode
  always_comb begin
    prop_len = {1'b0, cfg_reg.propagation_length_field} + 4'h1;
    ps1_len = {1'b0, cfg_reg.phase_one_length_field} + 4'h1;
    jump_len = {1'b0, cfg_reg.jump_width} + 3'h1;
    jump_w = {2'b00, jump_len};
    if (cfg_reg.phase_two_length_select) begin
      ps2_len = {1'b0, cfg_reg.phase_two_length_field} + 4'h1;
    end else if (ps1_len > CBT_PROCESSING_TIME) begin
      ps2_len = ps1_len;
    end else begin
      ps2_len = CBT_PROCESSING_TIME;
    end
    // decoded phase two never below the processing time; a shortened one can drop to CBT_MIN_PH2
    if (ps2_len < CBT_PROCESSING_TIME) begin
      ps2_len = CBT_PROCESSING_TIME;
    end
  end

  // ---------------- wishbone slave, one wait state per access
  // write lands at the taking edge, the same edge that raises ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= CBT_CONFIG_RST;
    end else if (wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg &
                 wb_adr_i == CBT_CONFIG_OFF) begin
      if (wb_sel_i[0]) begin
        cfg_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cfg_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        cfg_reg[CBT_CFG_W-1:16] <= wb_dat_i[CBT_CFG_W-1:16];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= CBT_UNMAPPED_DATA;
    end else if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
      unique case (wb_adr_i)
        CBT_CONFIG_OFF: rdata_reg <= {13'h0000, cfg_reg};
        CBT_STATUS_OFF: begin
          rdata_reg <= CBT_UNMAPPED_DATA;
          rdata_reg[CBT_ST_BIT] <= sample_reg;
          rdata_reg[CBT_ST_RX] <= rx_sync_reg;
          rdata_reg[CBT_ST_SEG_LSB +: 4] <= seg_reg;
        end
        CBT_COUNT_OFF: rdata_reg <= {hard_cnt_reg, resync_cnt_reg};
        default: rdata_reg <= CBT_UNMAPPED_DATA;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ---------------- receive line synchroniser
  // reset recessive, so no false edge right after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= can_rx_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // ---------------- quantum prescaler
  // a restart realigns the quantum grid to the edge
  // half quantum = field+1 clocks, so quantum = 2*(field+1) clocks
  assign half_tick = presc_cnt_reg == cfg_reg.quantum_prescaler;
  assign tq_tick = half_tick & half_ph_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i | restart) begin
      presc_cnt_reg <= 6'h00;
      half_ph_reg <= 1'b0;
    end else if (half_tick) begin
      presc_cnt_reg <= 6'h00;
      half_ph_reg <= ~half_ph_reg;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 6'h01;
    end
  end

  // ---------------- edge classification
  // error counted from the synchronised edge, two clocks late
  always_comb begin
    // falling edge seen with recessive previous sample
    fall_edge = rx_prev_reg & ~rx_sync_reg & sample_reg;
    edge_used = fall_edge & ~sync_done_reg;
    hard_sync = edge_used & bus_idle_i;
    pos_region = seg_reg == SEG_PROP || seg_reg == SEG_PH1;
    neg_region = seg_reg == SEG_PH2;
    if (seg_reg == SEG_PROP) begin
      err_pos = {1'b0, cnt_reg} + 5'h01;
    end else begin
      err_pos = {1'b0, prop_len} + {1'b0, cnt_reg} + 5'h01;
    end
    err_neg = {1'b0, ps2_eff_reg} - {1'b0, cnt_reg};
    restart = hard_sync |
              (edge_used & ~bus_idle_i & pos_region & ~transmitting_i &
               err_pos <= jump_w) |
              (edge_used & ~bus_idle_i & neg_region &
               err_neg <= jump_w);
    lengthen = edge_used & ~bus_idle_i & pos_region & ~transmitting_i &
               err_pos > jump_w;
    shorten = edge_used & ~bus_idle_i & neg_region &
              err_neg > jump_w;
    // floor keeps phase two alive when the jump is large
    if (ps2_eff_reg > {1'b0, jump_len} + CBT_MIN_PH2) begin
      ps2_short = ps2_eff_reg - {1'b0, jump_len};
    end else begin
      ps2_short = CBT_MIN_PH2;
    end
    sample_now = tq_tick & seg_reg == SEG_PH1 &
                 cnt_reg == ps1_eff_reg - 4'h1;
    bit_end = tq_tick & seg_reg == SEG_PH2 &
              cnt_reg + 4'h1 >= ps2_eff_reg;
    // two earlier half-quantum samples and the current level
    voted = (rx_sync_reg & hist_reg[0]) | (rx_sync_reg & hist_reg[1]) |
            (hist_reg[0] & hist_reg[1]);
  end

  // ---------------- bit time sequencer
  // one sync per bit: sync_done blocks any later edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_reg <= SEG_SYNC;
      cnt_reg <= 4'h0;
      ps1_eff_reg <= 4'h1;
      ps2_eff_reg <= CBT_PROCESSING_TIME;
      sync_done_reg <= 1'b0;
    end else if (restart) begin
      // edge now sits in the restarted sync segment
      seg_reg <= SEG_SYNC;
      cnt_reg <= 4'h0;
      ps1_eff_reg <= ps1_len;
      ps2_eff_reg <= ps2_len;
      sync_done_reg <= 1'b1;
    end else begin
      if (edge_used & ~bus_idle_i & seg_reg == SEG_SYNC) begin
        sync_done_reg <= 1'b1;
      end
      if (lengthen) begin
        ps1_eff_reg <= ps1_eff_reg + {1'b0, jump_len};
        sync_done_reg <= 1'b1;
      end
      if (shorten) begin
        ps2_eff_reg <= ps2_short;
        sync_done_reg <= 1'b1;
      end
      if (tq_tick) begin
        unique case (seg_reg)
          SEG_SYNC: begin
            if (cnt_reg + 4'h1 >= CBT_SYNC_LEN) begin
              seg_reg <= SEG_PROP;
              cnt_reg <= 4'h0;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          SEG_PROP: begin
            if (cnt_reg == prop_len - 4'h1) begin
              seg_reg <= SEG_PH1;
              cnt_reg <= 4'h0;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          SEG_PH1: begin
            if (sample_now & ~lengthen) begin
              seg_reg <= SEG_PH2;
              cnt_reg <= 4'h0;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          SEG_PH2: begin
            if (bit_end & ~shorten) begin
              seg_reg <= SEG_SYNC;
              cnt_reg <= 4'h0;
              ps1_eff_reg <= ps1_len;
              ps2_eff_reg <= ps2_len;
              sync_done_reg <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          default: begin
            seg_reg <= SEG_SYNC;
            cnt_reg <= 4'h0;
          end
        endcase
      end
    end
  end

  // ---------------- sampling and protocol engine side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_reg <= 2'b11;
    end else if (half_tick) begin
      hist_reg <= {hist_reg[0], rx_sync_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_reg <= 1'b1;
      rx_bit_o <= 1'b1;
      rx_bit_valid_o <= 1'b0;
    end else begin
      rx_bit_valid_o <= 1'b0;
      if (sample_now & ~lengthen & ~restart) begin
        // once per bit at the sample point
        if (cfg_reg.triple_sample_select) begin
          sample_reg <= voted;
          rx_bit_o <= voted;
        end else begin
          sample_reg <= rx_sync_reg;
          rx_bit_o <= rx_sync_reg;
        end
        rx_bit_valid_o <= 1'b1;
      end
    end
  end

  // transmit bit changes only at the start of a bit
  // tx_bit_i is taken in the cycle the bit restarts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_start_o <= 1'b0;
      can_tx_o <= 1'b1;
    end else begin
      bit_start_o <= restart | (bit_end & ~shorten);
      if (restart | (bit_end & ~shorten)) begin
        can_tx_o <= tx_bit_i;
      end
    end
  end

  // ---------------- diagnostic counters, wrap at full scale
  // kept apart so software can tell hard syncs from resyncs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resync_cnt_reg <= 16'h0000;
      hard_cnt_reg <= 16'h0000;
    end else begin
      if (hard_sync) begin
        hard_cnt_reg <= hard_cnt_reg + 16'h0001;
      end else if (restart | lengthen | shorten) begin
        resync_cnt_reg <= resync_cnt_reg + 16'h0001;
      end
    end
  end

endmodule

// ---- cbt_bus_node.sv ----
// remote node and transceiver model on the shared can line
`timescale 1ns/100ps
module cbt_bus_node (
  // line levels
  input wire logic node_tx_i,
  input wire logic core_tx_i,
  // receive path
  output logic rx_o
);
  // dominant zero wins, no transceiver delay to keep edges exact
  assign rx_o = node_tx_i & core_tx_i;
endmodule

// ---- cbt_core_assertions.sv ----
// port assertions for the can bit timing core
`timescale 1ns/100ps
module cbt_core_assertions
  import cbt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // can line and protocol engine
  input wire logic can_rx_i,
  input wire logic can_tx_o,
  input wire logic bus_idle_i,
  input wire logic transmitting_i,
  input wire logic tx_bit_i,
  input wire logic rx_bit_o,
  input wire logic rx_bit_valid_o,
  input wire logic bit_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // longest bit is 3712 clocks, so a gap this long means a lost sample
  logic [12:0] gap_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_bit_valid_o) begin
      gap_reg <= 13'h0000;
    end else if (gap_reg != 13'h1FFF) begin
      gap_reg <= gap_reg + 13'h0001;
    end
  end
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack stuck");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 4'hC
      |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_valid_pulse;
    rx_bit_valid_o |=> !rx_bit_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid");
  property p_start_pulse;
    bit_start_o |=> !bit_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start");
  property p_rx_hold;
    !rx_bit_valid_o |-> $stable(rx_bit_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx moved");
  property p_tx_hold;
    !bit_start_o && !$past(bit_start_o) |-> $stable(can_tx_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
  property p_gap;
    gap_reg < 13'h1000;
  endproperty
  a_gap: assert property (p_gap) else $error("no sample");
  property p_sample_late;
    bit_start_o |=> !rx_bit_valid_o [*4];
  endproperty
  a_sample_late: assert property (p_sample_late) else $error("early");
  property p_hard_sync;
    $fell(can_rx_i) && rx_bit_o && bus_idle_i ##1 bus_idle_i [*3]
      |-> ##[0:3] bit_start_o;
  endproperty
  a_hard_sync: assert property (p_hard_sync) else $error("no hard");
endmodule
bind cbt_core cbt_core_assertions cbt_core_assertions_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .can_rx_i(can_rx_i), .can_tx_o(can_tx_o), .bus_idle_i(bus_idle_i),
  .transmitting_i(transmitting_i), .tx_bit_i(tx_bit_i),
  .rx_bit_o(rx_bit_o), .rx_bit_valid_o(rx_bit_valid_o),
  .bit_start_o(bit_start_o));

// ---- cbt_core_test.sv ----
// self-checking bench for the can bit timing core
`timescale 1ns/100ps
module cbt_core_test
  import cbt_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic rx;
  logic tx;
  logic node = 1'b1;
  logic idle = 1'b1;
  logic xmit = 1'b0;
  logic rx_bit;
  logic rvld;
  logic bst;
  int mismatches = 0;
  int n_compared = 0;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  cbt_core cbt_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .can_rx_i(rx),
    .can_tx_o(tx), .bus_idle_i(idle), .transmitting_i(xmit),
    .tx_bit_i(1'b1), .rx_bit_o(rx_bit), .rx_bit_valid_o(rvld),
    .bit_start_o(bst));
  cbt_bus_node cbt_bus_node_i (.node_tx_i(node), .core_tx_i(tx), .rx_o(rx));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // edges until the chosen pulse is seen
  task automatic wt(input bit v, output int t);
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while ((v ? rvld : bst) !== 1'b1 && t < 5000);
  endtask
  function automatic logic [31:0] cf(int p, int j, int pr, int p1, int p2,
      logic ts, logic ls);
    return {13'h0000, ls, ts, p2[2:0], p1[2:0], pr[2:0], j[1:0], p[5:0]};
  endfunction
  function automatic int nominal_bit_time(int p, int pr, int p1, int p2, logic ls);
    int t2;
    t2 = ls ? p2 + 1 : p1 + 1;
    if (t2 < 2) t2 = 2;
    return 2 * (p + 1) * (3 + pr + p1 + t2);
  endfunction
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, CBT_CONFIG_OFF, 4'hF, 32'h0, q);
    check(q, 32'h00000000);
    wb(1'b1, CBT_CONFIG_OFF, 4'hF, 32'hFFFFFFFF, q);
    wb(1'b1, CBT_CONFIG_OFF, 4'h1, 32'h0, q);
    wb(1'b0, CBT_CONFIG_OFF, 4'hF, 32'h0, q);
    check(q, 32'h0007FF00);
    wb(1'b0, 4'hC, 4'hF, 32'h0, q);
    check(q, 32'h00000000);
  endtask
  task automatic t_period();
    logic [31:0] q;
    int t;
    // prescaler, prop, ph1, ph2 fields and select; segment order kept
    int k[5][5] = '{'{0, 0, 0, 0, 0}, '{1, 7, 7, 0, 0}, '{2, 4, 2, 7, 1},
      '{0, 0, 3, 0, 1}, '{63, 0, 0, 0, 0}};
    foreach (k[i]) begin
      wb(1'b1, CBT_CONFIG_OFF, 4'hF,
        cf(k[i][0], 0, k[i][1], k[i][2], k[i][3], 1'b0, k[i][4][0]), q);
      wt(1'b0, t);
      wt(1'b0, t);
      wt(1'b0, t);
      check(t, nominal_bit_time(k[i][0], k[i][1], k[i][2], k[i][3], k[i][4][0]));
    end
  endtask
  task automatic t_sample(input logic ts);
    logic [31:0] q;
    int t;
    wb(1'b1, CBT_CONFIG_OFF, 4'hF, cf(0, 0, 2, 3, 0, ts, 1'b0), q);
    idle <= 1'b0;
    node <= 1'b0;
    wt(1'b0, t);
    wt(1'b0, t);
    wt(1'b1, t);
    check(t, 2 * (1 + 3 + 4));
    check(rx_bit, 1'b0);
    node <= 1'b1;
    wt(1'b1, t);
    wt(1'b1, t);
    check(rx_bit, 1'b1);
  endtask
  // falling edge just after the sample point, prop 8 ph1 1 ph2 8 quanta
  task automatic t_resync(input int j, input logic lvl, input int exp);
    logic [31:0] q;
    int a;
    int b;
    wb(1'b1, CBT_CONFIG_OFF, 4'hF, cf(0, j, 7, 0, 7, 1'b0, 1'b1), q);
    idle <= 1'b0;
    node <= lvl;
    wt(1'b0, a);
    wt(1'b0, a);
    wt(1'b1, a);
    node <= 1'b1;
    @(posedge clk_i);
    node <= 1'b0;
    wt(1'b0, b);
    check(a + 1 + b, exp);
    node <= 1'b1;
  endtask
  task automatic t_hard();
    logic [31:0] q0;
    logic [31:0] q1;
    int t;
    idle <= 1'b1;
    wb(1'b0, CBT_COUNT_OFF, 4'hF, 32'h0, q0);
    wt(1'b1, t);
    wt(1'b1, t);
    repeat (2) @(posedge clk_i);
    node <= 1'b0;
    wt(1'b0, t);
    check(t, 4);
    wb(1'b0, CBT_COUNT_OFF, 4'hF, 32'h0, q1);
    check(q1, q0 + 32'h00010000);
    node <= 1'b1;
  endtask
  // falling edge early in propagation, prop 8 ph1 1 ph2 8, jump 1
  task automatic t_xmit(input logic x, input int exp);
    logic [31:0] q;
    int t;
    wb(1'b1, CBT_CONFIG_OFF, 4'hF, cf(0, 0, 7, 0, 7, 1'b0, 1'b1), q);
    idle <= 1'b0;
    xmit <= x;
    wt(1'b0, t);
    wt(1'b0, t);
    repeat (6) @(posedge clk_i);
    node <= 1'b0;
    wt(1'b0, t);
    check(t, exp);
    node <= 1'b1;
    xmit <= 1'b0;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_period();
    t_sample(1'b0);
    t_sample(1'b1);
    for (int j = 0; j < 4; j++) begin
      t_resync(j, 1'b1, 36 - 2 * (j + 1));
    end
    t_resync(0, 1'b0, 36);
    t_hard();
    t_xmit(1'b1, 36 - 6);
    t_xmit(1'b0, 36 - 6 + 2 * 1);
    give_verdict();
  end
endmodule
